// *** regs_pkg.sv ***
// register map, field layout, reset values and timing constants of the tuning register bank
package regs_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RATIO_HIGH   = 8'h40;
   localparam logic [7:0] ADDR_RATIO_LOW    = 8'h41;
   localparam logic [7:0] ADDR_ALERT_SETUP  = 8'h42;
   localparam logic [7:0] ADDR_OVLD_MUTE    = 8'h4B;
   localparam logic [7:0] ADDR_AUX_TIMING   = 8'h4C;
   localparam logic [7:0] ADDR_PWR_TUNE     = 8'h4E;
   localparam logic [7:0] ADDR_HELD_FLAGS   = 8'h44;
   localparam logic [7:0] ADDR_FLAG_MASK    = 8'h45;

   // ----------------------------------------------------------------
   // reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ALERT_SETUP   = 8'h00;
   localparam logic [7:0] RST_OVLD_MUTE     = 8'h00;
   localparam logic [7:0] RST_AUX_TIMING    = 8'h5C;
   localparam logic [7:0] RST_PWR_TUNE      = 8'h00;
   localparam logic [7:0] RST_FLAG_MASK     = 8'h00;
   localparam logic [7:0] WMASK_OVLD_MUTE   = 8'hF8;
   localparam logic [7:0] WMASK_AUX_TIMING  = 8'hFC;
   localparam logic [7:0] WMASK_PWR_TUNE    = 8'hFC;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POS_ALERT_POL    = 7;
   localparam int POS_EVENT_HI     = 6;
   localparam int POS_EVENT_LO     = 5;
   localparam int POS_PD_SEL_HI    = 4;
   localparam int POS_PD_SEL_LO    = 3;
   localparam int POS_READ_FILTER  = 2;
   localparam int POS_RECOVERY     = 1;
   localparam int POS_CLEAR_MODE   = 0;
   localparam int POS_CH1_SILENCE  = 4;
   localparam int POS_CH2_SILENCE  = 3;
   localparam int POS_SKIP_HI      = 7;
   localparam int POS_SKIP_LO      = 6;
   localparam int POS_RESET_HI     = 5;
   localparam int POS_RESET_LO     = 4;
   localparam int POS_OSR_HI       = 3;
   localparam int POS_OSR_LO       = 2;
   localparam int POS_CLK_HALVE    = 7;
   localparam int POS_COMB_ORDER   = 6;
   localparam int POS_FIR_SKIP     = 5;
   localparam int POS_LEAN_FILTER  = 2;

   // ----------------------------------------------------------------
   // widths and aux converter tables
   // ----------------------------------------------------------------
   localparam int RATIO_W      = 14;
   localparam int FLAG_W       = 8;
   localparam int INTERVAL_W   = 11;
   localparam logic [INTERVAL_W-1:0] SKIP_C0  = 11'd384;
   localparam logic [INTERVAL_W-1:0] SKIP_C1  = 11'd576;
   localparam logic [INTERVAL_W-1:0] SKIP_C2  = 11'd896;
   localparam logic [INTERVAL_W-1:0] SKIP_C3  = 11'd1024;
   localparam logic [INTERVAL_W-1:0] RESET_C0 = 11'd50;
   localparam logic [INTERVAL_W-1:0] RESET_C1 = 11'd75;
   localparam logic [INTERVAL_W-1:0] RESET_C2 = 11'd100;
   localparam logic [INTERVAL_W-1:0] RESET_C3 = 11'd150;
   localparam logic [7:0] OSR_C0 = 8'd32;
   localparam logic [7:0] OSR_C1 = 8'd64;
   localparam logic [7:0] OSR_C2 = 8'd96;
   localparam logic [7:0] OSR_C3 = 8'd128;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ         = 125_000_000;
   localparam int PULSE_MS       = 2;
   localparam int PERIOD_MS      = 4;
   localparam int PULSE_CYCLES   = CLK_HZ / 1000 * PULSE_MS;
   localparam int PERIOD_CYCLES  = CLK_HZ / 1000 * PERIOD_MS;
   localparam int TIMER_W        = 20;

   // alert event modes and fault power-down selections
   typedef enum logic [1:0] {EV_HELD_LEVEL, EV_LIVE_LEVEL, EV_HELD_PERIODIC, EV_EVENT_PULSE} alert_event_t;
   typedef enum logic [1:0] {PD_NEVER, PD_UNMASKED, PD_ALL, PD_RESERVED} pd_select_t;

endpackage

// *** alert_if.sv ***
// carrier between the register bank and the alert pulse generator
`timescale 1ns/1ps
interface alert_if;
   logic [1:0] event_mode;
   logic       polarity;
   logic       held_any;
   logic       live_any;
   logic       new_event;
   logic       alert_pin;

   modport bank  (output event_mode, output polarity, output held_any, output live_any, output new_event,
                  input alert_pin);
   modport timer (input event_mode, input polarity, input held_any, input live_any, input new_event,
                  output alert_pin);
endinterface

// *** alert_timer.sv ***
// alert output shaping: level, live, periodic and one-shot pulse modes
`timescale 1ns/1ps
module alert_timer #(
   parameter int PULSE_LEN  = regs_pkg::PULSE_CYCLES,
   parameter int PERIOD_LEN = regs_pkg::PERIOD_CYCLES
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // link to the register bank
   alert_if.timer    ai
);
   import regs_pkg::*;

   logic [TIMER_W-1:0] period_q;
   logic [TIMER_W-1:0] pulse_q;
   logic               active;

   // free-running 4 ms frame for the periodic mode, restarted while nothing is held
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         period_q <= '0;
      end else if (!ai.held_any || period_q == TIMER_W'(PERIOD_LEN - 1)) begin
         period_q <= '0;
      end else begin
         period_q <= period_q + 1'b1;
      end
   end

   // one-shot pulse counter; a new event retriggers the full length
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pulse_q <= '0;
      end else if (ai.new_event) begin
         pulse_q <= TIMER_W'(PULSE_LEN);
      end else if (pulse_q != '0) begin
         pulse_q <= pulse_q - 1'b1;
      end
   end

   // mode select
   always_comb begin
      case (alert_event_t'(ai.event_mode))
         EV_HELD_LEVEL:    active = ai.held_any;
         EV_LIVE_LEVEL:    active = ai.live_any;
         EV_HELD_PERIODIC: active = ai.held_any && (period_q < TIMER_W'(PULSE_LEN));
         default:          active = (pulse_q != '0);
      endcase
   end

   // output flop, polarity applied here so the pin never glitches
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ai.alert_pin <= 1'b1;
      end else begin
         ai.alert_pin <= ai.polarity ? active : !active;
      end
   end
endmodule

// *** tuning_regs.sv ***
// tuning, alert and fault control register bank of the stereo converter
`timescale 1ns/1ps
module tuning_regs #(
   parameter int PULSE_LEN  = regs_pkg::PULSE_CYCLES,
   parameter int PERIOD_LEN = regs_pkg::PERIOD_CYCLES
) (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           arst_n,
   // control port register access
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [7:0]                     reg_wdata,
   output logic      [7:0]                     reg_rdata,
   // ratio detector
   input  wire logic                           ratio_valid,
   input  wire logic [regs_pkg::RATIO_W-1:0]   ratio_meas,
   // flag and fault sources, live state
   input  wire logic [regs_pkg::FLAG_W-1:0]    flag_live,
   input  wire logic                           ovld_recover_1,
   input  wire logic                           ovld_recover_2,
   // alert pin
   output logic                                alert_out_low_active,
   // converter controls
   output logic                                chan_powerdown,
   output logic                                ch1_silence,
   output logic                                ch2_silence,
   output logic      [regs_pkg::INTERVAL_W-1:0] aux_skip_clocks,
   output logic      [regs_pkg::INTERVAL_W-1:0] aux_reset_clocks,
   output logic      [7:0]                     aux_osr,
   output logic                                modulator_clock_halve,
   output logic                                comb_filter_order,
   output logic                                decim_fir_skip,
   output logic                                lean_filter_enable
);
   import regs_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [RATIO_W-1:0] ratio_q;
   logic [7:0]         alert_setup_q;
   logic [7:0]         overload_mute_ctrl_q;
   logic [7:0]         aux_converter_timing_q;
   logic [7:0]         power_tune_ctrl_q;
   logic [FLAG_W-1:0]  flag_mask_q;
   logic [FLAG_W-1:0]  held_q;
   logic [FLAG_W-1:0]  held_d;
   logic [FLAG_W-1:0]  live_prev_q;
   logic               pd_latched_q;
   logic [7:0]         rdata_d;
   logic               fault_now;
   logic [FLAG_W-1:0]  rise;

   alert_if ai ();

   // skip interval decode, shared with any later consumer of the code
   function automatic logic [INTERVAL_W-1:0] skip_decode(input logic [1:0] code);
      case (code)
         2'd0:    skip_decode = SKIP_C0;
         2'd1:    skip_decode = SKIP_C1;
         2'd2:    skip_decode = SKIP_C2;
         default: skip_decode = SKIP_C3; // codes beyond 3 cannot exist here
      endcase
   endfunction

   function automatic logic [INTERVAL_W-1:0] reset_decode(input logic [1:0] code);
      case (code)
         2'd0:    reset_decode = RESET_C0;
         2'd1:    reset_decode = RESET_C1;
         2'd2:    reset_decode = RESET_C2;
         default: reset_decode = RESET_C3;
      endcase
   endfunction

   function automatic logic [7:0] osr_decode(input logic [1:0] code);
      case (code)
         2'd0:    osr_decode = OSR_C0;
         2'd1:    osr_decode = OSR_C1;
         2'd2:    osr_decode = OSR_C2;
         default: osr_decode = OSR_C3;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // ratio snapshot
   // ----------------------------------------------------------------
   // both halves load on one valid strobe so high and low never mix measurements
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ratio_q <= '0;
      end else if (ratio_valid) begin
         ratio_q <= ratio_meas;
      end
   end

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   // reserved bits are masked on write; software is expected to write reset values there anyway
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         alert_setup_q          <= RST_ALERT_SETUP;
         overload_mute_ctrl_q   <= RST_OVLD_MUTE;
         aux_converter_timing_q <= RST_AUX_TIMING;
         power_tune_ctrl_q      <= RST_PWR_TUNE;
         flag_mask_q            <= RST_FLAG_MASK;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_ALERT_SETUP) begin
            alert_setup_q <= reg_wdata;
         end else if (reg_addr == ADDR_OVLD_MUTE) begin
            overload_mute_ctrl_q <= reg_wdata & WMASK_OVLD_MUTE;
         end else if (reg_addr == ADDR_AUX_TIMING) begin
            aux_converter_timing_q <= reg_wdata & WMASK_AUX_TIMING;
         end else if (reg_addr == ADDR_PWR_TUNE) begin
            power_tune_ctrl_q <= reg_wdata & WMASK_PWR_TUNE;
         end else if (reg_addr == ADDR_FLAG_MASK) begin
            flag_mask_q <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // held flags
   // ----------------------------------------------------------------
   // a set in the same cycle as a read-clear wins, so no event is lost
   always_comb begin
      held_d = held_q;
      if (reg_rd && reg_addr == ADDR_HELD_FLAGS) begin
         if (alert_setup_q[POS_CLEAR_MODE]) begin
            held_d = '0;
         end else begin
            held_d = held_q & flag_live;
         end
      end
      held_d = held_d | flag_live;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         held_q      <= '0;
         live_prev_q <= '0;
      end else begin
         held_q      <= held_d;
         live_prev_q <= flag_live;
      end
   end

   assign rise = flag_live & ~live_prev_q & ~flag_mask_q;

   // ----------------------------------------------------------------
   // fault power-down
   // ----------------------------------------------------------------
   always_comb begin
      case (pd_select_t'(alert_setup_q[POS_PD_SEL_HI:POS_PD_SEL_LO]))
         PD_UNMASKED: fault_now = |(flag_live & ~flag_mask_q);
         PD_ALL:      fault_now = |flag_live;
         default:     fault_now = 1'b0;                        // reserved acts as none
      endcase
   end

   // manual recovery holds the power-down until software writes the setup register once the fault has gone
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pd_latched_q <= 1'b0;
      end else if (fault_now) begin
         pd_latched_q <= alert_setup_q[POS_RECOVERY];
      end else if (!alert_setup_q[POS_RECOVERY] || (reg_wr && reg_addr == ADDR_ALERT_SETUP)) begin
         pd_latched_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         chan_powerdown <= 1'b0;
      end else begin
         chan_powerdown <= fault_now || pd_latched_q;
      end
   end

   // ----------------------------------------------------------------
   // overload silence and converter settings
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ch1_silence <= 1'b0;
         ch2_silence <= 1'b0;
      end else begin
         ch1_silence <= overload_mute_ctrl_q[POS_CH1_SILENCE] && ovld_recover_1;
         ch2_silence <= overload_mute_ctrl_q[POS_CH2_SILENCE] && ovld_recover_2;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         aux_skip_clocks       <= SKIP_C1;
         aux_reset_clocks      <= RESET_C1;
         aux_osr               <= OSR_C3;
         modulator_clock_halve <= 1'b0;
         comb_filter_order     <= 1'b0;
         decim_fir_skip        <= 1'b0;
         lean_filter_enable    <= 1'b0;
      end else begin
         aux_skip_clocks       <= skip_decode(aux_converter_timing_q[POS_SKIP_HI:POS_SKIP_LO]);
         aux_reset_clocks      <= reset_decode(aux_converter_timing_q[POS_RESET_HI:POS_RESET_LO]);
         aux_osr               <= osr_decode(aux_converter_timing_q[POS_OSR_HI:POS_OSR_LO]);
         modulator_clock_halve <= power_tune_ctrl_q[POS_CLK_HALVE];
         comb_filter_order     <= power_tune_ctrl_q[POS_COMB_ORDER];
         decim_fir_skip        <= power_tune_ctrl_q[POS_FIR_SKIP];
         lean_filter_enable    <= power_tune_ctrl_q[POS_LEAN_FILTER];
      end
   end

   // ----------------------------------------------------------------
   // alert generation
   // ----------------------------------------------------------------
   assign ai.event_mode = alert_setup_q[POS_EVENT_HI:POS_EVENT_LO];
   assign ai.polarity   = alert_setup_q[POS_ALERT_POL];
   assign ai.held_any   = |(held_q & ~flag_mask_q);
   assign ai.live_any   = |(flag_live & ~flag_mask_q);
   assign ai.new_event  = |rise;

   alert_timer #(
      .PULSE_LEN  (PULSE_LEN),
      .PERIOD_LEN (PERIOD_LEN)
   ) u_alert (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ai      (ai)
   );

   assign alert_out_low_active = ai.alert_pin;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // unmapped addresses read as zero
   always_comb begin
      rdata_d = 8'h00;
      if (reg_addr == ADDR_RATIO_HIGH) begin
         rdata_d = {2'b00, ratio_q[RATIO_W-1:8]};
      end else if (reg_addr == ADDR_RATIO_LOW) begin
         rdata_d = ratio_q[7:0];
      end else if (reg_addr == ADDR_ALERT_SETUP) begin
         rdata_d = alert_setup_q;
      end else if (reg_addr == ADDR_OVLD_MUTE) begin
         rdata_d = overload_mute_ctrl_q;
      end else if (reg_addr == ADDR_AUX_TIMING) begin
         rdata_d = aux_converter_timing_q;
      end else if (reg_addr == ADDR_PWR_TUNE) begin
         rdata_d = power_tune_ctrl_q;
      end else if (reg_addr == ADDR_FLAG_MASK) begin
         rdata_d = flag_mask_q;
      end else if (reg_addr == ADDR_HELD_FLAGS) begin
         rdata_d = alert_setup_q[POS_READ_FILTER] ? (held_q & ~flag_mask_q) : held_q;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end
endmodule

// *** tuning_regs_assertions.sv ***
// concurrent checks on the ports of the tuning register bank
`timescale 1ns/1ps
module tuning_regs_assertions (
   // clock and reset
   input wire logic                         clk_sys,
   input wire logic                         arst_n,
   // register port
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_addr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic [7:0]                   reg_rdata,
   // measurement and overload inputs
   input wire logic                         ratio_valid,
   input wire logic [regs_pkg::RATIO_W-1:0] ratio_meas,
   input wire logic                         ovld_recover_1,
   input wire logic                         ovld_recover_2,
   // converter controls
   input wire logic                         ch1_silence,
   input wire logic                         ch2_silence,
   input wire logic [regs_pkg::INTERVAL_W-1:0] aux_skip_clocks,
   input wire logic [regs_pkg::INTERVAL_W-1:0] aux_reset_clocks,
   input wire logic [7:0]                   aux_osr,
   input wire logic                         modulator_clock_halve,
   input wire logic                         comb_filter_order,
   input wire logic                         decim_fir_skip,
   input wire logic                         lean_filter_enable
);
   import regs_pkg::*;
   logic              wr_pwr;
   logic              wr_aux;
   logic [RATIO_W-1:0] snap_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   assign wr_pwr = reg_wr && reg_addr == ADDR_PWR_TUNE;
   assign wr_aux = reg_wr && reg_addr == ADDR_AUX_TIMING;
   // own copy of the last measurement, so reads can be judged without the design's snapshot
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) snap_q <= '0;
      else if (ratio_valid) snap_q <= ratio_meas;
   end
   chk_pwr_tune_copy: assert property (
      wr_pwr |=> ##1 {modulator_clock_halve, comb_filter_order, decim_fir_skip, lean_filter_enable}
         == {$past(reg_wdata[7:5], 2), $past(reg_wdata[2], 2)})
      else $error("power tune outputs differ from written bits");
   chk_skip_top_code: assert property (
      wr_aux && reg_wdata[7:6] == 2'b11 |=> ##1 aux_skip_clocks == 11'd1024)
      else $error("skip interval code 3 not decoded");
   chk_reset_top_code: assert property (
      wr_aux && reg_wdata[5:4] == 2'b11 |=> ##1 aux_reset_clocks == 11'd150)
      else $error("reset interval code 3 not decoded");
   chk_osr_low_code: assert property (
      wr_aux && reg_wdata[3:2] == 2'b00 |=> ##1 aux_osr == 8'd32)
      else $error("oversampling code 0 not decoded");
   chk_ch1_quiet: assert property (!ovld_recover_1 [*2] |=> !ch1_silence)
      else $error("channel 1 silenced outside recovery");
   chk_ch2_quiet: assert property (!ovld_recover_2 [*2] |=> !ch2_silence)
      else $error("channel 2 silenced outside recovery");
   chk_ratio_low_read: assert property (
      reg_rd && reg_addr == ADDR_RATIO_LOW && !ratio_valid |=> reg_rdata == snap_q[7:0])
      else $error("ratio low byte read wrong");
   chk_ratio_high_read: assert property (
      reg_rd && reg_addr == ADDR_RATIO_HIGH && !ratio_valid |=> reg_rdata == {2'b00, snap_q[13:8]})
      else $error("ratio high bits read wrong");
   cov_pwr_write: cover property (wr_pwr);
   cov_ratio_read: cover property (reg_rd && reg_addr == ADDR_RATIO_HIGH);
   cov_ch2_mute: cover property ($rose(ch2_silence));
endmodule

// *** tb_top.sv ***
// self-checking bench for the tuning register bank
`timescale 1ns/1ps
module tb_top;
   import regs_pkg::*;
   localparam int PL = 20;
   localparam int PR = 40;
   logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ratio_valid = 1'b0;
   logic ovld_recover_1 = 1'b0, ovld_recover_2 = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, flag_live = 8'h00, reg_rdata, aux_osr, d;
   logic [13:0] ratio_meas = 14'h0000, r;
   logic [10:0] aux_skip_clocks, aux_reset_clocks;
   logic alert_out_low_active, chan_powerdown, ch1_silence, ch2_silence;
   logic modulator_clock_halve, comb_filter_order, decim_fir_skip, lean_filter_enable;
   int miscompares = 0, num_checks = 0, k;
   int skip_m[4] = '{384, 576, 896, 1024};
   int rst_m[4] = '{50, 75, 100, 150};
   always #4 clk_sys = ~clk_sys;
   // short pulse figures keep the periodic alert modes cheap to watch
   tuning_regs #(.PULSE_LEN(PL), .PERIOD_LEN(PR)) tuning_regs_i (.*);
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // inputs move 1 ns after the edge, never on it
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cyc(1);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
      cyc(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cyc(1);
      {reg_rd, reg_addr} = {1'b1, a};
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
      check($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
   endtask
   // alert is active low while the polarity bit is clear
   task automatic count_active(input int n);
      k = 0;
      repeat (n) begin
         cyc(1);
         if (alert_out_low_active === 1'b0) k++;
      end
   endtask
   task automatic pulse_flag(input logic [7:0] f);
      flag_live = f;
      cyc(1);
      flag_live = 8'h00;
      cyc(3);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      final_report();
   end
   initial begin
      void'($urandom(32'hCFFA));
      cyc(8);
      arst_n = 1'b1;
      check("skip rst", aux_skip_clocks, 16'd576);
      check("reset rst", aux_reset_clocks, 16'd75);
      check("osr rst", aux_osr, 16'd128);
      check("alert rst", alert_out_low_active, 16'd1);
      rd(ADDR_ALERT_SETUP, 8'h00);
      rd(ADDR_AUX_TIMING, 8'h5C);
      for (int c = 0; c < 4; c++) begin
         d = {c[1:0], c[1:0], c[1:0], 2'b00};
         wr(ADDR_AUX_TIMING, d);
         rd(ADDR_AUX_TIMING, d);
         check("skip", aux_skip_clocks, 16'(skip_m[c]));
         check("reset", aux_reset_clocks, 16'(rst_m[c]));
         check("osr", aux_osr, 16'(32 * (c + 1)));
         d = 8'($urandom) & 8'hE4;
         wr(ADDR_PWR_TUNE, d);
         rd(ADDR_PWR_TUNE, d);
         check("tune", {modulator_clock_halve, comb_filter_order, decim_fir_skip, lean_filter_enable},
               {d[7:5], d[2]});
      end
      r = 14'($urandom);
      {ratio_meas, ratio_valid} = {r, 1'b1};
      cyc(1);
      {ratio_meas, ratio_valid} = {~r, 1'b0};
      wr(ADDR_RATIO_LOW, 8'hFF);
      rd(ADDR_RATIO_LOW, r[7:0]);
      rd(ADDR_RATIO_HIGH, {2'b00, r[13:8]});
      wr(ADDR_OVLD_MUTE, 8'h10);
      {ovld_recover_1, ovld_recover_2} = 2'b11;
      cyc(3);
      check("ch1 mute", {ch1_silence, ch2_silence}, 16'd2);
      wr(ADDR_OVLD_MUTE, 8'h08);
      cyc(2);
      check("ch2 mute", {ch1_silence, ch2_silence}, 16'd1);
      {ovld_recover_1, ovld_recover_2} = 2'b00;
      cyc(3);
      check("mute off", {ch1_silence, ch2_silence}, 16'd0);
      pulse_flag(8'h01);
      check("held level", alert_out_low_active, 16'd0);
      rd(ADDR_HELD_FLAGS, 8'h01);
      cyc(3);
      check("level off", alert_out_low_active, 16'd1);
      flag_live = 8'h02;
      rd(ADDR_HELD_FLAGS, 8'h02);
      flag_live = 8'h00;
      rd(ADDR_HELD_FLAGS, 8'h02);
      rd(ADDR_HELD_FLAGS, 8'h00);
      wr(ADDR_FLAG_MASK, 8'h01);
      wr(ADDR_ALERT_SETUP, 8'h04);
      pulse_flag(8'h03);
      rd(ADDR_HELD_FLAGS, 8'h02);
      wr(ADDR_ALERT_SETUP, 8'h00);
      pulse_flag(8'h03);
      rd(ADDR_HELD_FLAGS, 8'h03);
      wr(ADDR_ALERT_SETUP, 8'h20);
      for (int i = 0; i < 3; i++) begin
         flag_live = 8'h01 << i;
         cyc(4);
         check("live", alert_out_low_active, (i == 0) ? 16'd1 : 16'd0);
      end
      wr(ADDR_ALERT_SETUP, 8'hA0);
      pulse_flag(8'h00);
      check("polarity idle", alert_out_low_active, 16'd0);
      flag_live = 8'h02;
      cyc(4);
      check("polarity act", alert_out_low_active, 16'd1);
      wr(ADDR_ALERT_SETUP, 8'h60);
      flag_live = 8'h00;
      cyc(PR);
      flag_live = 8'h02;
      count_active(3 * PL);
      check("one pulse", 16'(k), 16'(PL));
      flag_live = 8'h00;
      wr(ADDR_ALERT_SETUP, 8'h40);
      cyc(PR);
      count_active(4 * PR);
      check("periodic", 16'(k), 16'(4 * PL));
      wr(ADDR_ALERT_SETUP, 8'h41);
      rd(ADDR_HELD_FLAGS, 8'h07);
      cyc(PR);
      count_active(PR);
      check("periodic off", 16'(k), 16'd0);
      wr(ADDR_ALERT_SETUP, 8'h00);
      for (int i = 0; i < 6; i++) begin
         if (i == 2) wr(ADDR_ALERT_SETUP, 8'h08);
         if (i == 4) wr(ADDR_ALERT_SETUP, 8'h10);
         flag_live = 8'h01 << i[0];
         cyc(4);
         check("pd", chan_powerdown, 16'((i == 3) || (i >= 4)));
      end
      flag_live = 8'h00;
      cyc(4);
      check("auto up", chan_powerdown, 16'd0);
      wr(ADDR_ALERT_SETUP, 8'h18);
      flag_live = 8'h02;
      cyc(4);
      check("pd reserved", chan_powerdown, 16'd0);
      flag_live = 8'h01;
      wr(ADDR_ALERT_SETUP, 8'h12);
      // the fault must still stand once manual recovery is armed
      cyc(2);
      flag_live = 8'h00;
      cyc(4);
      check("manual hold", chan_powerdown, 16'd1);
      wr(ADDR_ALERT_SETUP, 8'h12);
      cyc(4);
      check("manual up", chan_powerdown, 16'd0);
      final_report();
   end
endmodule
bind tuning_regs tuning_regs_assertions tuning_regs_assertions_i (.*);
